// file: logic/fault_code_pkg.sv
// package for the servo fault code detector: alarm codes, register map, field layout
// assumes a 32-bit apb slave at 250 mhz and digitised analog limit samples
package fault_code_pkg;

	// ********************************
	// alarm codes
	// ********************************
	localparam logic [7:0] CODE_NONE      = 8'h00;
	localparam logic [7:0] CODE_ABS_SPEED = 8'h2F; // 47
	localparam logic [7:0] CODE_Z_MISS    = 8'h30; // 48
	localparam logic [7:0] CODE_CS_BAD    = 8'h31; // 49
	localparam logic [7:0] CODE_SCALE0    = 8'h32; // 50, scale bit n adds n
	localparam logic [7:0] CODE_CCW_XS    = 8'h41; // 65
	localparam logic [7:0] CODE_CW_XS     = 8'h42; // 66
	localparam logic [7:0] CODE_MISMATCH  = 8'h5F; // 95
	localparam logic [7:0] CODE_OTHER     = 8'hFF; // outside all listed codes

	// ********************************
	// control mode and selection encodings
	// ********************************
	localparam logic [3:0] MODE_POS      = 4'h0;
	localparam logic [3:0] MODE_VEL      = 4'h1;
	localparam logic [3:0] MODE_TRQ      = 4'h2;
	localparam logic [3:0] MODE_POS_VEL  = 4'h3;
	localparam logic [3:0] MODE_POS_TRQ  = 4'h4;
	localparam logic [3:0] MODE_VEL_TRQ  = 4'h5;
	localparam logic [3:0] MODE_FULL_CL  = 4'h6;
	localparam logic [3:0] TLSEL_ANALOG  = 4'h0;
	localparam logic [3:0] TCMD_SEL_ONE  = 4'h1;

	// ********************************
	// register byte offsets
	// ********************************
	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_STATUS  = 8'h04;
	localparam logic [7:0] OFF_CLEAR   = 8'h08;
	localparam logic [7:0] OFF_ENABLE  = 8'h0C;
	localparam logic [7:0] OFF_CODE    = 8'h10;
	localparam logic [7:0] OFF_LIMIT   = 8'h14;
	localparam logic [7:0] OFF_SPEED   = 8'h18;

	// ctrl fields
	localparam int CTRL_MODE_LSB  = 0;
	localparam int CTRL_TLSEL_LSB = 4;
	localparam int CTRL_TCMD_LSB  = 8;
	localparam int CTRL_SCLR_BIT  = 12; // scale clear request, arms a flag held until reset
	localparam int CTRL_ACLR_BIT  = 13; // alarm clear for non-scale alarms

	// status / enable bit positions
	localparam int ST_ABS_SPEED = 0;
	localparam int ST_Z_MISS    = 1;
	localparam int ST_CS_BAD    = 2;
	localparam int ST_SCALE     = 3;
	localparam int ST_CCW_XS    = 4;
	localparam int ST_CW_XS     = 5;
	localparam int ST_MISMATCH  = 6;
	localparam int ST_OTHER     = 7;
	localparam int ST_WIDTH     = 8;

	// reset values
	localparam logic [15:0] LIMIT_RESET = 16'h7FFF; // +-10 v full scale
	localparam logic [15:0] SPEED_RESET = 16'h0100;

	// time
	localparam int CLK_MHZ       = 250;
	localparam int SAMPLE_US     = 100;
	localparam int SAMPLE_CYCLES = SAMPLE_US * CLK_MHZ;

endpackage

// file: logic/servo_fault_code_detector.sv
// servo fault code detector: turns encoder, scale, limit and self test conditions into alarm codes
// assumes an apb master on pclk, samples of the analog inputs from an adc on pclk,
// and discrete fault pins from the encoder side that need synchronising;
// the scale code and the other level inputs are already on pclk
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps

module servo_fault_code_detector
	import fault_code_pkg::*;
#(
	parameter int SAMPLE_DIV = fault_code_pkg::SAMPLE_CYCLES
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [7:0]   paddr,
	input  wire logic [31:0]  pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	input  wire logic         power_on_window,
	input  wire logic [15:0]  abs_speed_in,
	input  wire logic         z_missing_pin,
	input  wire logic         cs_invalid_pin,
	input  wire logic [5:0]   ext_scale_fault_code,
	input  wire logic signed [15:0] ccw_torque_limit_in,
	input  wire logic signed [15:0] cw_torque_limit_in,
	input  wire logic         motor_mismatch,
	input  wire logic         self_test_fail,
	output logic              alarm,
	output logic [7:0]        alarm_code,
	output logic              irq
);
	import fault_code_pkg::*;

	// elaboration check: a divider below one could never produce a sample tick
	if (SAMPLE_DIV < 1) begin : g_div_check
		$error("sample divider must be at least one");
	end

	// ********************************
	// registers
	// ********************************
	// software settings and thresholds, plus the sticky status and latched code
	logic [3:0]          control_mode_param;
	logic [3:0]          torque_limit_select_param;
	logic [3:0]          torque_cmd_select_param;
	logic                alarm_clear_reg;
	logic [ST_WIDTH-1:0] status_reg;
	logic [ST_WIDTH-1:0] enable_reg;
	logic [7:0]          code_reg;
	logic [15:0]         limit_reg;
	logic [15:0]         speed_reg;
	// alarm memory that outlives the fault itself
	logic                scale_clear_pend_reg;
	logic [5:0]          scale_hold_reg;
	// sampling and pin conditioning
	logic [31:0]         sample_cnt_reg;
	logic                sample_tick;
	logic [2:0]          z_sync_reg;
	logic [2:0]          cs_sync_reg;
	logic                z_stable_reg;
	logic                cs_stable_reg;
	// decoded events, mode gates and bus strobes
	logic [ST_WIDTH-1:0] event_vec;
	logic [7:0]          event_code;
	logic                ccw_check_en;
	logic                cw_check_en;
	logic                wr_acc;
	logic [ST_WIDTH-1:0] clear_bits;
	logic                addr_hit;

	// magnitude test against the excess threshold, used for both inputs
	function automatic logic exceeds(input logic signed [15:0] v, input logic [15:0] lim);
		logic [15:0] mag;
		mag = v[15] ? 16'(-v) : 16'(v);
		return mag > lim;
	endfunction

	// first set event bit in priority order gives the code
	// the scale code names the lowest set fault bit
	function automatic logic [7:0] code_of(input logic [ST_WIDTH-1:0] ev, input logic [5:0] sc);
		logic [7:0] c;
		c = CODE_NONE;
		if (ev[ST_OTHER])         c = CODE_OTHER;
		else if (ev[ST_MISMATCH]) c = CODE_MISMATCH;
		else if (ev[ST_ABS_SPEED]) c = CODE_ABS_SPEED;
		else if (ev[ST_Z_MISS])   c = CODE_Z_MISS;
		else if (ev[ST_CS_BAD])   c = CODE_CS_BAD;
		else if (ev[ST_SCALE]) begin
			for (int n = 5; n >= 0; n--) begin
				if (sc[n]) c = 8'(CODE_SCALE0 + 8'(n));
			end
		end
		else if (ev[ST_CCW_XS])   c = CODE_CCW_XS;
		else if (ev[ST_CW_XS])    c = CODE_CW_XS;
		return c;
	endfunction

	// ********************************
	// apb slave, zero wait states
	// ********************************
	assign pready  = 1'b1;
	assign wr_acc  = psel && penable && pwrite;
	// every mapped offset; an access anywhere else answers with an error and changes nothing
	assign addr_hit = (paddr == OFF_CTRL)   ||
		(paddr == OFF_STATUS) ||
		(paddr == OFF_CLEAR)  ||
		(paddr == OFF_ENABLE) ||
		(paddr == OFF_CODE)   ||
		(paddr == OFF_LIMIT)  ||
		(paddr == OFF_SPEED);
	assign pslverr = psel && penable && !addr_hit;
	assign clear_bits = (wr_acc && paddr == OFF_CLEAR) ? pwdata[ST_WIDTH-1:0] : '0;

	// control and threshold registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_mode_param        <= MODE_POS;
			torque_limit_select_param <= TLSEL_ANALOG;
			torque_cmd_select_param   <= 4'h0;
			alarm_clear_reg           <= 1'b0;
			enable_reg                <= '0;
			limit_reg                 <= LIMIT_RESET;
			speed_reg                 <= SPEED_RESET;
		end else begin
			alarm_clear_reg <= 1'b0; // one-cycle pulse
			if (wr_acc) begin
				case (paddr)
					OFF_CTRL: begin
						control_mode_param        <= pwdata[CTRL_MODE_LSB +: 4];
						torque_limit_select_param <= pwdata[CTRL_TLSEL_LSB +: 4];
						torque_cmd_select_param   <= pwdata[CTRL_TCMD_LSB +: 4];
						alarm_clear_reg           <= pwdata[CTRL_ACLR_BIT];
					end
					OFF_ENABLE: enable_reg <= pwdata[ST_WIDTH-1:0];
					OFF_LIMIT:  limit_reg  <= pwdata[15:0];
					OFF_SPEED:  speed_reg  <= pwdata[15:0];
					default: ;
				endcase
			end
		end
	end

	// scale clear is only armed here; the alarm itself goes away at the next power-off reset
	// the armed flag is readable so software can see that the request was taken
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scale_clear_pend_reg <= 1'b0;
		end else if (wr_acc && paddr == OFF_CTRL && pwdata[CTRL_SCLR_BIT]) begin
			scale_clear_pend_reg <= 1'b1;
		end
	end

	// read mux, registered data held stable
	// captured in the setup cycle, so the value stands through the whole access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				OFF_CTRL:   prdata <= {18'h0, scale_clear_pend_reg, 1'b0, torque_cmd_select_param,
					torque_limit_select_param, control_mode_param};
				OFF_STATUS: prdata <= {24'h0, status_reg};
				OFF_ENABLE: prdata <= {24'h0, enable_reg};
				OFF_CODE:   prdata <= {18'h0, scale_hold_reg, code_reg};
				OFF_LIMIT:  prdata <= {16'h0, limit_reg};
				OFF_SPEED:  prdata <= {16'h0, speed_reg};
				default:    prdata <= 32'h0000_0000;
			endcase
		end
	end

	// ********************************
	// input conditioning
	// ********************************
	// three-stage synchronisers; a change counts when stages two and three agree
	// stage one may go metastable, so only stage two reads it;
	// the agreement test costs one more edge of latency but rejects single-edge glitches
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			z_sync_reg    <= 3'b000;
			cs_sync_reg   <= 3'b000;
			z_stable_reg  <= 1'b0;
			cs_stable_reg <= 1'b0;
		end else begin
			z_sync_reg  <= {z_sync_reg[1:0], z_missing_pin};
			cs_sync_reg <= {cs_sync_reg[1:0], cs_invalid_pin};
			if (z_sync_reg[1] == z_sync_reg[2])
				z_stable_reg <= z_sync_reg[2];
			if (cs_sync_reg[1] == cs_sync_reg[2])
				cs_stable_reg <= cs_sync_reg[2];
		end
	end

	// sample period divider; a slow adc does not need a compare every cycle
	// the tick is one cycle wide and comes every SAMPLE_DIV cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sample_cnt_reg <= 32'h0000_0000;
		end else if (sample_cnt_reg >= 32'(SAMPLE_DIV - 1)) begin
			sample_cnt_reg <= 32'h0000_0000;
		end else begin
			sample_cnt_reg <= sample_cnt_reg + 32'h0000_0001;
		end
	end
	assign sample_tick = (sample_cnt_reg >= 32'(SAMPLE_DIV - 1));

	// ********************************
	// check enables by mode
	// ********************************
	// the gates follow the settings live; a setting change mid-period
	// takes effect at the very next tick, there is no settling delay
	// ccw: velocity-torque always, torque and position-torque by command selection, or any mode with analog limits
	always_comb begin
		ccw_check_en = (control_mode_param == MODE_VEL_TRQ) ||
			((control_mode_param == MODE_TRQ || control_mode_param == MODE_POS_TRQ) &&
			torque_cmd_select_param == TCMD_SEL_ONE) ||
			(torque_limit_select_param == TLSEL_ANALOG);
		// analog limits only: position family per mode table, plus velocity
		cw_check_en = (torque_limit_select_param == TLSEL_ANALOG) &&
			(control_mode_param == MODE_POS || control_mode_param == MODE_VEL ||
			control_mode_param == MODE_POS_VEL || control_mode_param == MODE_POS_TRQ ||
			control_mode_param == MODE_FULL_CL);
	end

	// ********************************
	// events
	// ********************************
	// conditions are levels; the sticky status and the alarm latch give them memory
	// limit excess is looked at only on the sample tick, so a spike between ticks is missed
	always_comb begin
		event_vec               = '0;
		event_vec[ST_ABS_SPEED] = power_on_window && (abs_speed_in > speed_reg);
		event_vec[ST_Z_MISS]    = z_stable_reg;
		event_vec[ST_CS_BAD]    = cs_stable_reg;
		event_vec[ST_SCALE]     = |ext_scale_fault_code;
		event_vec[ST_CCW_XS]    = sample_tick && ccw_check_en && exceeds(ccw_torque_limit_in, limit_reg);
		event_vec[ST_CW_XS]     = sample_tick && cw_check_en && exceeds(cw_torque_limit_in, limit_reg);
		event_vec[ST_MISMATCH]  = motor_mismatch;
		event_vec[ST_OTHER]     = self_test_fail;
		event_code              = code_of(event_vec, ext_scale_fault_code);
	end

	// sticky status; a new event wins over a clear, scale bit ignores software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_reg <= '0;
		end else begin
			for (int i = 0; i < ST_WIDTH; i++) begin
				if (event_vec[i])
					status_reg[i] <= 1'b1;
				else if (clear_bits[i] && i != ST_SCALE)
					status_reg[i] <= 1'b0;
			end
		end
	end

	// scale alarm bits kept until reset, even if the scale recovers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scale_hold_reg <= 6'h00;
		end else begin
			scale_hold_reg <= scale_hold_reg | ext_scale_fault_code;
		end
	end

	// first alarm code latched; scale alarms only leave through reset
	// simultaneous causes resolve by the priority inside code_of, so the code
	// names the most severe cause; later causes still show in the status bits.
	// a software clear is ignored while any cause is active, otherwise the
	// alarm would drop and re-raise with a possibly different code
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			code_reg <= CODE_NONE;
			alarm    <= 1'b0;
		end else if (!alarm && event_vec != '0) begin
			code_reg <= event_code;
			alarm    <= 1'b1;
		end else if (alarm && alarm_clear_reg && scale_hold_reg == 6'h00 && event_vec == '0) begin
			code_reg <= CODE_NONE;
			alarm    <= 1'b0;
		end
	end

	// outputs straight from registers; irq is a level, not a pulse, and
	// stays up until software clears or masks every enabled status bit
	assign alarm_code = code_reg;
	assign irq        = |(status_reg & enable_reg);

endmodule // servo_fault_code_detector

// file: bench/fault_code_monitor.sv
// concurrent checks on the fault detector's top ports
// assumes it is bound into servo_fault_code_detector, one pclk domain
`timescale 1ns/10ps
module fault_code_monitor
	import fault_code_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pslverr,
	input wire logic        power_on_window,
	input wire logic [15:0] abs_speed_in,
	input wire logic        z_missing_pin,
	input wire logic        cs_invalid_pin,
	input wire logic [5:0]  ext_scale_fault_code,
	input wire logic        motor_mismatch,
	input wire logic        self_test_fail,
	input wire logic        alarm,
	input wire logic [7:0]  alarm_code
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ****************
	// alarm relations
	// ****************
	// no alarm yet and nothing of the top rank competing
	wire logic quiet = !alarm && !self_test_fail;
	logic clr_seen;
	// an alarm may only fall one edge after a clear write commits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) clr_seen <= 1'b0;
		else clr_seen <= psel && penable && pwrite && paddr == OFF_CTRL && pwdata[CTRL_ACLR_BIT];
	end
	a_code_holds: assert property (alarm |=> !alarm || $stable(alarm_code)) else $error("code moved");
	a_clear_cause: assert property ($fell(alarm) |-> $past(clr_seen)) else $error("alarm fell unasked");
	a_other_code: assert property (!alarm && self_test_fail |=> alarm_code == CODE_OTHER) else $error("no 255");
	a_mismatch_code: assert property (quiet && motor_mismatch |=> alarm_code == CODE_MISMATCH) else $error("no 95");
	a_speed_code: assert property (quiet && !motor_mismatch && power_on_window && abs_speed_in > SPEED_RESET
		|=> alarm_code == CODE_ABS_SPEED) else $error("no 47");
	a_scale_code: assert property (quiet && !motor_mismatch && $onehot(ext_scale_fault_code)
		|=> (6'h01 << (alarm_code - CODE_SCALE0)) == $past(ext_scale_fault_code)) else $error("bad scale code");
	a_scale_held: assert property (alarm && alarm_code >= CODE_SCALE0 && alarm_code < 8'h38 |=> alarm)
		else $error("scale alarm dropped");
	a_zmiss_code: assert property (quiet && $rose(z_missing_pin) |-> ##[1:5] alarm && alarm_code == CODE_Z_MISS)
		else $error("no 48");
	a_cs_code: assert property (quiet && $rose(cs_invalid_pin) |-> ##[1:5] alarm && alarm_code == CODE_CS_BAD)
		else $error("no 49");
	c_scale_top: cover property (alarm && alarm_code == 8'h37);
	c_cleared: cover property ($fell(alarm));
	c_refused: cover property (psel && penable && pslverr);
endmodule // fault_code_monitor

// file: bench/encoder_side_model.sv
// encoder, scale, limit and self test inputs, behavioural
// assumes the bench picks one fault at a time through fault_sel
`timescale 1ns/10ps
module encoder_side_model (
	input  wire logic          clk,
	input  wire logic [3:0]    fault_sel,
	input  wire logic [2:0]    scale_n,
	output logic               power_on_window,
	output logic [15:0]        abs_speed_in,
	output logic               z_missing_pin,
	output logic               cs_invalid_pin,
	output logic [5:0]         ext_scale_fault_code,
	output logic signed [15:0] ccw_torque_limit_in,
	output logic signed [15:0] cw_torque_limit_in,
	output logic               motor_mismatch,
	output logic               self_test_fail
);
	// ****************
	// sensor behaviour
	// ****************
	// quiet levels before the first edge
	initial begin
		{power_on_window, abs_speed_in, z_missing_pin, cs_invalid_pin, ext_scale_fault_code} = '0;
		{ccw_torque_limit_in, cw_torque_limit_in, motor_mismatch, self_test_fail} = '0;
	end
	// healthy values wander randomly inside the limits so a stuck compare shows up
	always @(posedge clk) begin
		power_on_window <= 1'b1;
		abs_speed_in <= (fault_sel == 4'd1) ? 16'h0200 : 16'($urandom_range(255));
		z_missing_pin <= (fault_sel == 4'd2);
		cs_invalid_pin <= (fault_sel == 4'd3);
		ccw_torque_limit_in <= (fault_sel == 4'd4) ? 16'sh5000 : $signed(16'($urandom_range(16383)));
		cw_torque_limit_in <= (fault_sel == 4'd5) ? -16'sh5000 : -$signed(16'($urandom_range(16383)));
		motor_mismatch <= (fault_sel == 4'd6);
		self_test_fail <= (fault_sel == 4'd7);
		ext_scale_fault_code <= (fault_sel == 4'd8) ? 6'(1 << scale_n) : 6'h00;
	end
endmodule // encoder_side_model

// file: bench/servo_fault_code_detector_test.sv
// self-checking bench for the servo fault code detector
// assumes the package, design, model and monitor are compiled first
`timescale 1ns/10ps
module servo_fault_code_detector_test;
	import fault_code_pkg::*;
	// ****************
	// stimulus and checking
	// ****************
	logic               pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, last_err;
	logic [7:0]         paddr = 8'h00;
	logic [31:0]        pwdata = 32'h0000_0000, prdata, d;
	logic               pready, pslverr, power_on_window, z_missing_pin, cs_invalid_pin;
	logic               motor_mismatch, self_test_fail, alarm, irq;
	logic [7:0]         alarm_code;
	logic [15:0]        abs_speed_in;
	logic [5:0]         ext_scale_fault_code;
	logic signed [15:0] ccw_torque_limit_in, cw_torque_limit_in;
	logic [3:0]         fsel = 4'h0;
	logic [2:0]         scale_n = 3'h0;
	logic [7:0]         exp_q[$];
	int                 n_errors = 0, check_count = 0;
	// ctrl(12) fault(4) code(8) status(8)
	localparam logic [31:0] TBL [15] = '{32'h0001_2F01, 32'h0002_3002, 32'h0003_3104, 32'h0004_4110,
		32'h0005_4220, 32'h0006_5F40, 32'h0007_FF80, 32'h0104_0000, 32'h0154_4110, 32'h1144_4110,
		32'h0124_0000, 32'h0025_0000, 32'h0165_0000, 32'h0065_4220, 32'h0035_4220};

	servo_fault_code_detector #(.SAMPLE_DIV(4)) u_servo_fault_code_detector (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .power_on_window, .abs_speed_in, .z_missing_pin,
		.cs_invalid_pin, .ext_scale_fault_code, .ccw_torque_limit_in, .cw_torque_limit_in, .motor_mismatch,
		.self_test_fail, .alarm, .alarm_code, .irq);
	encoder_side_model u_encoder_side_model (.clk(pclk), .fault_sel(fsel), .scale_n, .power_on_window,
		.abs_speed_in, .z_missing_pin, .cs_invalid_pin, .ext_scale_fault_code, .ccw_torque_limit_in,
		.cw_torque_limit_in, .motor_mismatch, .self_test_fail);

	always #2 pclk = ~pclk;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task stop_test;
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// one apb transfer; waits an edge first so no signal is driven twice in a step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge pclk);
		psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1); // only the watchdog ends a stuck wait
		rd = prdata;
		last_err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask

	task automatic do_reset;
		presetn <= 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
	endtask

	// raise one fault under one mode, check code, status, mask, then clear
	task automatic run_fault(input logic [31:0] t);
		logic [31:0] r;
		apb(1'b1, OFF_CTRL, 32'(t[31:20]), r);
		if (t[15:8] !== CODE_NONE) exp_q.push_back(t[15:8]);
		@(posedge pclk) fsel <= t[19:16];
		repeat (16) @(posedge pclk);
		chk(32'(alarm), 32'(t[15:8] !== CODE_NONE));
		fsel <= 4'd0;
		apb(1'b1, OFF_ENABLE, 32'h0000_0000, r);
		apb(1'b0, OFF_STATUS, 32'h0000_0000, r);
		chk(32'(r[7:0]), 32'(t[7:0]));
		chk(32'(irq), 32'h0000_0000);
		apb(1'b1, OFF_ENABLE, 32'h0000_00FF, r);
		apb(1'b0, OFF_CODE, 32'h0000_0000, r);
		chk(32'(r[7:0]), 32'(t[15:8]));
		chk(32'(irq), 32'(t[7:0] != 8'h00));
		apb(1'b1, OFF_CLEAR, 32'h0000_00FF, r);
		apb(1'b1, OFF_CTRL, 32'(t[31:20]) | 32'h0000_2000, r);
		apb(1'b0, OFF_STATUS, 32'h0000_0000, r);
		chk(32'(r[7:0]), 32'h0000_0000);
		chk(32'(alarm), 32'h0000_0000);
	endtask

	// every new alarm is compared against the oldest expected code
	always @(posedge alarm) begin
		#1;
		chk(32'(alarm_code), 32'(exp_q.size() > 0 ? exp_q.pop_front() : CODE_NONE));
	end

	// whole run is under a thousand cycles
	initial begin
		repeat (30000) @(posedge pclk);
		n_errors++;
		stop_test();
	end

	initial begin
		void'($urandom(16));
		do_reset();
		apb(1'b0, OFF_LIMIT, 32'h0000_0000, d);
		chk(d, 32'h0000_7FFF);
		apb(1'b0, OFF_SPEED, 32'h0000_0000, d);
		chk(d, 32'h0000_0100);
		apb(1'b0, 8'h1C, 32'h0000_0000, d);
		chk({d[31:1], last_err}, 32'h0000_0001);
		apb(1'b1, OFF_LIMIT, 32'h0000_4000, d);
		apb(1'b1, OFF_ENABLE, 32'h0000_00FF, d);
		foreach (TBL[i]) run_fault(TBL[i]);
		// scale alarms survive a clear request and leave only through reset
		for (int n = 0; n < 6; n++) begin
			exp_q.push_back(CODE_SCALE0 + 8'(n));
			@(posedge pclk) begin
				scale_n <= 3'(n);
				fsel <= 4'd8;
			end
			repeat (4) @(posedge pclk);
			fsel <= 4'd0;
			apb(1'b1, OFF_CTRL, 32'h0000_3000, d);
			apb(1'b0, OFF_CODE, 32'h0000_0000, d);
			chk(32'(d[13:0]), 32'({6'(1 << n), CODE_SCALE0 + 8'(n)}));
			chk(32'(alarm), 32'h0000_0001);
			do_reset();
			chk(32'(alarm), 32'h0000_0000);
		end
		chk(32'(exp_q.size()), 32'h0000_0000);
		stop_test();
	end
endmodule // servo_fault_code_detector_test

bind servo_fault_code_detector fault_code_monitor u_fault_code_monitor (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pslverr, .power_on_window, .abs_speed_in, .z_missing_pin, .cs_invalid_pin,
	.ext_scale_fault_code, .motor_mismatch, .self_test_fail, .alarm, .alarm_code);
